// ### sdr_pkg.sv
package sdr_pkg;
  // ==========================================
  // geometry
  localparam int NUM_CH = 4;
  localparam int ACC_W  = 40;
  localparam int DATA_W = 24;
  localparam int PRE_SHIFT = 8;

  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFS_CLK_CFG2 = 8'h00;
  localparam logic [7:0] OFS_ASC      = 8'h04;
  localparam logic [7:0] OFS_STAT1    = 8'h08;
  localparam logic [7:0] OFS_STATP    = 8'h0c;
  localparam logic [7:0] OFS_STATN    = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_DATA0    = 8'h1c;
  localparam logic [7:0] OFS_DATA3    = 8'h28;

  // ==========================================
  // field positions and reset values
  localparam int OSR_LSB       = 0;
  localparam int TH_LSB        = 0;
  localparam int INTREF_BIT    = 3;
  localparam int V4_BIT        = 4;
  localparam int FAULT_BIT     = 0;
  localparam int IRQ_CONV_BIT  = 0;
  localparam int IRQ_RANGE_BIT = 1;
  localparam logic [3:0] OSR_RST = 4'h0;
  localparam logic [4:0] ASC_RST = 5'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // ==========================================
  // timing
  localparam int CLK_NS        = 10;
  localparam int READY_LOW_NS  = 40;
  localparam int READY_LOW_CYC = (READY_LOW_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================
  // gain multipliers: 1.0, 1072/2^24*15625, 19/512*27
  localparam logic [10:0] M_K1  = 11'h001;
  localparam logic [10:0] M_KLO = 11'h430;
  localparam logic [10:0] M_KHI = 11'h013;

  typedef struct packed {
    logic [12:0] ratio;
    logic [10:0] mult;
    logic [5:0]  shift;
  } sdr_osr_cfg_t;

  function automatic sdr_osr_cfg_t sdr_osr_decode(input logic [3:0] code);
    sdr_osr_cfg_t c;
    unique case (code)
      4'h0: c = '{13'h1000, M_K1, 6'h15};
      4'h1: c = '{13'h0800, M_K1, 6'h12};
      4'h2: c = '{13'h0400, M_K1, 6'h0f};
      4'h3: c = '{13'h0320, M_KLO, 6'h18};
      4'h4: c = '{13'h0300, M_KHI, 6'h12};
      4'h5: c = '{13'h0200, M_K1, 6'h0c};
      4'h6: c = '{13'h0190, M_KLO, 6'h15};
      4'h7: c = '{13'h0180, M_KHI, 6'h0f};
      4'h8: c = '{13'h0100, M_K1, 6'h09};
      4'h9: c = '{13'h00c8, M_KLO, 6'h12};
      4'ha: c = '{13'h00c0, M_KHI, 6'h0c};
      4'hb: c = '{13'h0080, M_K1, 6'h06};
      4'hc: c = '{13'h0060, M_KHI, 6'h09};
      4'hd: c = '{13'h0040, M_K1, 6'h03};
      4'he: c = '{13'h0030, M_KHI, 6'h06};
      4'hf: c = '{13'h0020, M_K1, 6'h00};
    endcase
    return c;
  endfunction : sdr_osr_decode
endpackage : sdr_pkg

// ### sdr_sinc3_chan.sv
`timescale 1ns/1ns
module sdr_sinc3_chan (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 sample_strobe,
  input  wire logic                 mod_bit,
  input  wire logic                 dec_tick,
  input  wire sdr_pkg::sdr_osr_cfg_t cfg,
  output logic [sdr_pkg::DATA_W-1:0] data_r,
  output logic                      valid_r
);
  // ==========================================
  // integrators, wrap-around is harmless
  logic signed [sdr_pkg::ACC_W-1:0] i1_r, i2_r, i3_r;
  logic signed [sdr_pkg::ACC_W-1:0] d1_r, d2_r, d3_r, raw_r;
  logic signed [sdr_pkg::ACC_W-1:0] x, c1, c2, c3;
  logic                             raw_v_r;
  logic signed [63:0]               prod, scaled;
  logic [sdr_pkg::DATA_W-1:0]       sat;

  assign x  = mod_bit ? 40'sh00_0000_0001 : -40'sh00_0000_0001;
  assign c1 = i3_r - d1_r;
  assign c2 = c1 - d2_r;
  assign c3 = c2 - d3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i1_r <= '0;
      i2_r <= '0;
      i3_r <= '0;
    end else if (sample_strobe) begin
      i1_r <= i1_r + x;
      i2_r <= i2_r + i1_r;
      i3_r <= i3_r + i2_r;
    end
  end

  // ==========================================
  // comb section at the output rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d1_r    <= '0;
      d2_r    <= '0;
      d3_r    <= '0;
      raw_r   <= '0;
      raw_v_r <= 1'b0;
    end else begin
      raw_v_r <= dec_tick;
      if (dec_tick) begin
        d1_r  <= i3_r;
        d2_r  <= c1;
        d3_r  <= c2;
        raw_r <= c3;
      end
    end
  end

  // ==========================================
  // RL4 divide by N cubed
  // RL5 gain folded into multiplier
  assign prod   = (64'(raw_r) * $signed({53'h0, cfg.mult})) <<< sdr_pkg::PRE_SHIFT;
  assign scaled = prod >>> cfg.shift;
  // RL14 truncate and saturate
  assign sat = (scaled > 64'sh7f_ffff) ? 24'h7f_ffff :
               (scaled < -64'sh80_0000) ? 24'h80_0000 : scaled[23:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r  <= '0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= raw_v_r;
      if (raw_v_r) data_r <= sat;
    end
  end
endmodule : sdr_sinc3_chan

// ### sdr_decim_top.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// RL1: each channel has its own sinc3 filter fed by its modulator bit.
// RL2: one word per channel every N modulator samples.
// RL3: four-bit ratio field in clock_config_two, shared by all channels.
// RL4: response is K times cubed N-tap moving sum over N.
// RL5: K is 1.0, 0.9983778 or 1.00195313 depending on ratio family.
// RL6: two comparators per channel, thresholds from three-bit code.
// RL7: fault flag sets when any input pin crosses threshold.
// RL8: per-pin positive and negative status registers record the culprit.
// RL9: one select bit, reset zero picks external reference.
// RL10: level bit picks 2.442 or 4.0 volts, ignored on external.
// RL11: host keeps low reference when charge pump runs at low supply.
// RL12: completion shown by a falling edge of conversion_ready_n.
// RL13: no output gating after wake-up; early words unsettled.
// RL14: result truncated and saturated to 24-bit two's complement.
// RL15: fault flag and pin bits stay set until software reads them.
module sdr_decim_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      mod_sample_strobe,
  input  wire logic [sdr_pkg::NUM_CH-1:0] mod_bits,
  input  wire logic [sdr_pkg::NUM_CH-1:0] pos_cmp_trip,
  input  wire logic [sdr_pkg::NUM_CH-1:0] neg_cmp_trip,
  output logic [2:0]                     range_threshold_code,
  output logic                           ref_internal_en,
  output logic                           ref_4v_en,
  output logic                           conversion_ready_n,
  output logic                           irq
);
  // ==========================================
  // declarations
  logic [3:0]                osr_code_r;
  logic [4:0]                asc_r;
  logic                      fault_r;
  logic [sdr_pkg::NUM_CH-1:0] statp_r, statn_r;
  logic [1:0]                irq_stat_r, irq_mask_r;
  logic [31:0]               rdata_r;
  logic [12:0]               dec_cnt_r;
  logic [2:0]                ready_cnt_r;
  logic [sdr_pkg::DATA_W-1:0] ch_data [sdr_pkg::NUM_CH];
  logic [sdr_pkg::NUM_CH-1:0] ch_valid;
  sdr_pkg::sdr_osr_cfg_t     cfg;

  // ==========================================
  // apb decode
  wire setup     = psel & ~penable;
  wire access    = psel & penable;
  wire wr        = access & pwrite;
  wire rd        = access & ~pwrite;
  wire aligned   = (paddr[1:0] == 2'b00);
  wire hit_ratio = aligned & (paddr == sdr_pkg::OFS_CLK_CFG2);
  wire hit_asc   = aligned & (paddr == sdr_pkg::OFS_ASC);
  wire hit_stat1 = aligned & (paddr == sdr_pkg::OFS_STAT1);
  wire hit_statp = aligned & (paddr == sdr_pkg::OFS_STATP);
  wire hit_statn = aligned & (paddr == sdr_pkg::OFS_STATN);
  wire hit_istat = aligned & (paddr == sdr_pkg::OFS_IRQ_STAT);
  wire hit_imask = aligned & (paddr == sdr_pkg::OFS_IRQ_MASK);
  wire hit_data  = aligned & (paddr >= sdr_pkg::OFS_DATA0) & (paddr <= sdr_pkg::OFS_DATA3);
  wire mapped    = hit_ratio | hit_asc | hit_stat1 | hit_statp | hit_statn |
                   hit_istat | hit_imask | hit_data;
  wire [7:0] data_ofs = paddr - sdr_pkg::OFS_DATA0;
  wire [1:0] data_idx = data_ofs[3:2];

  // zero wait state; unmapped gets an error and reads zero
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = rdata_r;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ratio) rd_mux[3:0] = osr_code_r;
    if (hit_asc)   rd_mux[4:0] = asc_r;
    if (hit_stat1) rd_mux[sdr_pkg::FAULT_BIT] = fault_r;
    if (hit_statp) rd_mux[sdr_pkg::NUM_CH-1:0] = statp_r;
    if (hit_statn) rd_mux[sdr_pkg::NUM_CH-1:0] = statn_r;
    if (hit_istat) rd_mux[1:0] = irq_stat_r;
    if (hit_imask) rd_mux[1:0] = irq_mask_r;
    if (hit_data)  rd_mux[sdr_pkg::DATA_W-1:0] = ch_data[data_idx];
  end

  // read data captured in setup; clears use this snapshot so a
  // flag set between setup and access survives the read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rdata_r <= 32'h0000_0000;
    else if (setup) rdata_r <= rd_mux;
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osr_code_r <= sdr_pkg::OSR_RST;
      asc_r      <= sdr_pkg::ASC_RST;
      irq_mask_r <= sdr_pkg::IRQ_RST;
    end else if (wr) begin
      // RL3 global ratio field
      if (hit_ratio) osr_code_r <= pwdata[sdr_pkg::OSR_LSB +: 4];
      if (hit_asc)   asc_r <= pwdata[4:0];
      if (hit_imask) irq_mask_r <= pwdata[1:0];
    end
  end

  // RL6 threshold code to comparator dac
  assign range_threshold_code = asc_r[sdr_pkg::TH_LSB +: 3];
  // RL9 reference source select
  assign ref_internal_en = asc_r[sdr_pkg::INTREF_BIT];
  // RL10 level ignored on external
  assign ref_4v_en = asc_r[sdr_pkg::INTREF_BIT] & asc_r[sdr_pkg::V4_BIT];

  // ==========================================
  // decimation timing, shared by all channels
  assign cfg = sdr_pkg::sdr_osr_decode(osr_code_r);
  wire       cnt_last = (dec_cnt_r == (cfg.ratio - 13'h0001));
  // RL2 one word per n samples
  wire       dec_tick = mod_sample_strobe & cnt_last;
  wire       osr_wr   = wr & hit_ratio;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dec_cnt_r <= '0;
    else if (osr_wr) dec_cnt_r <= '0;
    else if (dec_tick) dec_cnt_r <= '0;
    else if (mod_sample_strobe) dec_cnt_r <= dec_cnt_r + 13'h0001;
  end

  // ==========================================
  // filter channels
  // RL1 one filter per channel
  for (genvar g = 0; g < sdr_pkg::NUM_CH; g++) begin : g_ch
    sdr_sinc3_chan u_chan (
      .pclk          (pclk),
      .presetn       (presetn),
      .sample_strobe (mod_sample_strobe),
      .mod_bit       (mod_bits[g]),
      .dec_tick      (dec_tick),
      .cfg           (cfg),
      .data_r        (ch_data[g]),
      .valid_r       (ch_valid[g])
    );
  end

  // RL13 first words are not suppressed
  wire conv_done = ch_valid[0];

  // ==========================================
  // data ready strobe, held low a short while
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ready_cnt_r <= '0;
    // RL12 falling edge on completion
    else if (conv_done) ready_cnt_r <= 3'(sdr_pkg::READY_LOW_CYC);
    else if (ready_cnt_r != 3'h0) ready_cnt_r <= ready_cnt_r - 3'h1;
  end
  assign conversion_ready_n = (ready_cnt_r == 3'h0);

  // ==========================================
  // range flags
  wire any_trip  = |pos_cmp_trip | |neg_cmp_trip;
  wire clr_fault = rd & hit_stat1 & rdata_r[sdr_pkg::FAULT_BIT];
  wire [sdr_pkg::NUM_CH-1:0] clr_p = (rd & hit_statp) ? rdata_r[sdr_pkg::NUM_CH-1:0] : '0;
  wire [sdr_pkg::NUM_CH-1:0] clr_n = (rd & hit_statn) ? rdata_r[sdr_pkg::NUM_CH-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
      statp_r <= '0;
      statn_r <= '0;
    end else begin
      // RL7 fault on any pin
      // RL15 sticky until read, set wins
      fault_r <= (fault_r & ~clr_fault) | any_trip;
      // RL8 per-pin record
      statp_r <= (statp_r & ~clr_p) | pos_cmp_trip;
      statn_r <= (statn_r & ~clr_n) | neg_cmp_trip;
    end
  end

  // ==========================================
  // interrupt status, write one to clear
  wire [1:0] irq_evt = {any_trip, conv_done};
  wire [1:0] irq_w1c = (wr & hit_istat) ? pwdata[1:0] : 2'b00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_stat_r <= sdr_pkg::IRQ_RST;
    else irq_stat_r <= (irq_stat_r & ~irq_w1c) | irq_evt;
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // ==========================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr_ratio;
    wr && hit_ratio;
  endsequence
  sequence s_wr_asc;
    wr && hit_asc;
  endsequence

  property p_ratio_wr;
    s_wr_ratio |=> osr_code_r == $past(pwdata[3:0]) && dec_cnt_r == 13'h0000;
  endproperty
  a_ratio_wr: assert property (p_ratio_wr) else $error("ratio write lost"); // RL3

  property p_tick_spacing;
    dec_tick |=> dec_cnt_r == 13'h0000 ##0 (!dec_tick) [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("bad tick"); // RL2

  property p_word_follows;
    dec_tick ##1 !osr_wr |=> ch_valid == {sdr_pkg::NUM_CH{1'b1}};
  endproperty
  a_word_follows: assert property (p_word_follows) else $error("no word"); // RL1

  property p_gain_hi;
    osr_code_r == 4'h4 |-> cfg.mult == 11'h013 && cfg.ratio == 13'h0300;
  endproperty
  a_gain_hi: assert property (p_gain_hi) else $error("gain 768 wrong"); // RL5

  property p_ready_fall;
    conv_done |=> !conversion_ready_n [*4] ##1 conversion_ready_n || conv_done;
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("ready pulse"); // RL12

  property p_ref_sel;
    s_wr_asc |=> ref_internal_en == $past(pwdata[3]);
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("ref select"); // RL9

  property p_ref_level;
    s_wr_asc |=> ref_4v_en == ($past(pwdata[3]) && $past(pwdata[4]));
  endproperty
  a_ref_level: assert property (p_ref_level) else $error("4v on ext"); // RL10

  property p_fault_set;
    any_trip |=> fault_r && (statp_r | statn_r) != '0;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault missed"); // RL7

  property p_pin_rec;
    pos_cmp_trip[0] |=> statp_r[0];
  endproperty
  a_pin_rec: assert property (p_pin_rec) else $error("pin not kept"); // RL8

  property p_fault_hold;
    fault_r && !(rd && hit_stat1) |=> fault_r;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped"); // RL15

  sequence s_rd_stat1;
    rd && hit_stat1;
  endsequence

  property p_fault_clear;
    s_rd_stat1 ##0 (rdata_r[sdr_pkg::FAULT_BIT] && !any_trip) |=> !fault_r;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared"); // RL15

  property p_neg_rec;
    neg_cmp_trip != '0 |=> (statn_r & $past(neg_cmp_trip)) == $past(neg_cmp_trip);
  endproperty
  a_neg_rec: assert property (p_neg_rec) else $error("neg pin not kept"); // RL8

  property p_range_irq;
    any_trip |=> irq_stat_r[sdr_pkg::IRQ_RANGE_BIT];
  endproperty
  a_range_irq: assert property (p_range_irq) else $error("range irq missed"); // RL7

  property p_range_w1c;
    wr && hit_istat && pwdata[sdr_pkg::IRQ_RANGE_BIT] && !any_trip
      |=> !irq_stat_r[sdr_pkg::IRQ_RANGE_BIT];
  endproperty
  a_range_w1c: assert property (p_range_w1c) else $error("range irq kept"); // RL7

  property p_conv_irq;
    conv_done |=> irq_stat_r[sdr_pkg::IRQ_CONV_BIT];
  endproperty
  a_conv_irq: assert property (p_conv_irq) else $error("conv irq missed"); // RL12

  property p_ready_idle;
    conversion_ready_n && !conv_done |=> conversion_ready_n;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("stray ready fall"); // RL12

  property p_word_only;
    $changed(ch_data[0]) |-> ch_valid[0];
  endproperty
  a_word_only: assert property (p_word_only) else $error("word without tick"); // RL2

  property p_thresh;
    s_wr_asc |=> range_threshold_code == $past(pwdata[2:0]);
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold code"); // RL6

  property p_osr_hold;
    !osr_wr |=> $stable(osr_code_r);
  endproperty
  a_osr_hold: assert property (p_osr_hold) else $error("ratio drifted"); // RL3

endmodule : sdr_decim_top

// ### sdr_mod_model.sv
`timescale 1ns/1ns
// ==========================================
// modulator bitstream stand-in, one strobe per sample
module sdr_mod_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic [7:0] mode,
  output logic            strobe,
  output logic [3:0]      bits
);
  logic [1:0] gap_r;
  logic [1:0] ph_r;
  integer     seed = 32'hc77e1a04;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r  <= 2'h1;
      ph_r   <= 2'h0;
      strobe <= 1'b0;
      bits   <= 4'h0;
    end else if (gap_r == 2'h0) begin
      // slow mode stretches spacing at random
      gap_r  <= slow ? (2'($random(seed)) | 2'h1) : 2'h1;
      ph_r   <= ph_r + 2'h1;
      strobe <= 1'b1;
      // modes: 0 all -1, 1 all +1, 2 alternate, 3 three in four
      for (int c = 0; c < 4; c++) begin
        bits[c] <= mode[2*c+1] ? (mode[2*c] ? (ph_r != 2'h3) : ph_r[0]) : mode[2*c];
      end
    end else begin
      gap_r  <= gap_r - 2'h1;
      strobe <= 1'b0;
      // outside a sample the line carries no stale value
      bits   <= ~bits;
    end
  end
endmodule : sdr_mod_model

// ### tb_sinc3_decimator_range_flags.sv
`timescale 1ns/1ns
module tb_sinc3_decimator_range_flags;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slow, rdy_q;
  logic        ref_internal_en, ref_4v_en, conversion_ready_n, mod_sample_strobe;
  logic [31:0] pwdata, prdata, v;
  logic [7:0]  paddr, mode;
  logic [3:0]  mod_bits, pos_cmp_trip, neg_cmp_trip;
  logic [2:0]  range_threshold_code;
  logic [32:0] exp_rd [$];
  int          exp_n [$];
  int          n_mismatch, comparisons, nstb, low, cyc;
  integer      seed = 32'hc77e1a04;
  logic [3:0]  cx [3] = '{4'hf, 4'he, 4'h9};
  logic [23:0] dx [3][4] = '{'{24'h7fffff, 24'h800000, 24'h000000, 24'h400000},
                            '{24'h7fffff, 24'h800000, 24'h000000, 24'h402000},
                            '{24'h7fcad8, 24'h803528, 24'h000000, 24'h3fe56c}};
  int          nt [16] = '{4096, 2048, 1024, 800, 768, 512, 400, 384, 256, 200, 192,
                           128, 96, 64, 48, 32};

  sdr_decim_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mod_sample_strobe, .mod_bits, .pos_cmp_trip,
    .neg_cmp_trip, .range_threshold_code, .ref_internal_en, .ref_4v_en,
    .conversion_ready_n, .irq);
  sdr_mod_model u_mod (.pclk, .presetn, .slow, .mode, .strobe(mod_sample_strobe),
    .bits(mod_bits));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========================================
  // shared tasks
  task check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  // stale completions are skipped: n falls pass first, then two clocks
  task wait_conv(input int n);
    repeat (n) @(negedge conversion_ready_n);
    repeat (2) @(posedge pclk);
  endtask : wait_conv

  task test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // ==========================================
  // monitors: read data, strobes per word, ready pulse, timeout
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, exp_rd.pop_front());
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      test_done();
    end
    if (rdy_q === 1'b1 && conversion_ready_n === 1'b0) begin
      if (exp_n.size() > 0) check(33'(nstb), 33'(exp_n.pop_front()));
      nstb = 0;
      low = 1;
    end else if (conversion_ready_n === 1'b0) begin
      low++;
    end else if (low > 0) begin
      check(33'(low), 33'(sdr_pkg::READY_LOW_CYC));
      low = 0;
    end
    nstb += int'(mod_sample_strobe);
    rdy_q = conversion_ready_n;
  end

  // ==========================================
  // main sequence
  initial begin
    {psel, penable, pwrite, slow, presetn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pos_cmp_trip = 4'h0;
    neg_cmp_trip = 4'h0;
    mode = 8'he1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1 check(33'({range_threshold_code, ref_internal_en, ref_4v_en}), 33'h0);
    rd(sdr_pkg::OFS_CLK_CFG2, 33'h0);
    rd(sdr_pkg::OFS_ASC, 33'h0);
    rd(8'h30, 33'h100000000);
    xfer(1'b1, sdr_pkg::OFS_ASC, 32'h1d);
    #1 check(33'({range_threshold_code, ref_internal_en, ref_4v_en}), 33'h17);
    // level bit without internal source must stay inert
    xfer(1'b1, sdr_pkg::OFS_ASC, 32'h15);
    #1 check(33'({range_threshold_code, ref_internal_en, ref_4v_en}), 33'h14);
    rd(sdr_pkg::OFS_ASC, 33'h15);
    xfer(1'b1, sdr_pkg::OFS_ASC, 32'h0d);
    #1 check(33'({range_threshold_code, ref_internal_en, ref_4v_en}), 33'h16);
    v = $random(seed);
    @(posedge pclk);
    pos_cmp_trip <= v[3:0] | 4'h1;
    neg_cmp_trip <= v[7:4];
    @(posedge pclk);
    pos_cmp_trip <= 4'h0;
    neg_cmp_trip <= 4'h0;
    #1 check(33'(irq), 33'h0);
    rd(sdr_pkg::OFS_STAT1, 33'h1);
    rd(sdr_pkg::OFS_STATP, 33'(v[3:0] | 4'h1));
    rd(sdr_pkg::OFS_STATN, 33'(v[7:4]));
    rd(sdr_pkg::OFS_STAT1, 33'h0);
    rd(sdr_pkg::OFS_STATP, 33'h0);
    rd(sdr_pkg::OFS_IRQ_STAT, 33'h2);
    xfer(1'b1, sdr_pkg::OFS_IRQ_MASK, 32'h2);
    #1 check(33'(irq), 33'h1);
    xfer(1'b1, sdr_pkg::OFS_IRQ_STAT, 32'h2);
    #1 check(33'(irq), 33'h0);
    rd(sdr_pkg::OFS_IRQ_STAT, 33'h0);
    // settled words for each gain family, last one with slow strobes
    for (int i = 0; i < 3; i++) begin
      slow <= (i == 2);
      xfer(1'b1, sdr_pkg::OFS_CLK_CFG2, 32'(cx[i]));
      wait_conv(5);
      for (int c = 0; c < 4; c++) begin
        rd(sdr_pkg::OFS_DATA0 + 8'(4 * c), 33'(dx[i][c]));
      end
    end
    slow <= 1'b0;
    xfer(1'b1, sdr_pkg::OFS_IRQ_MASK, 32'h1);
    rd(sdr_pkg::OFS_IRQ_STAT, 33'h1);
    #1 check(33'(irq), 33'h1);
    // every ratio code, one full word counted per code
    for (int c = 0; c < 16; c++) begin
      xfer(1'b1, sdr_pkg::OFS_CLK_CFG2, 32'(c));
      wait_conv(2);
      exp_n.push_back(nt[c]);
      wait_conv(1);
    end
    test_done();
  end
endmodule : tb_sinc3_decimator_range_flags
